//--- rmacd_top.sv
// Receive MAC: link sampling, frame control, staging, FIFO, arbitration, duplex
// Function
// - Received frame wins over a pending transmit that has not started.
// - A transmit in progress keeps priority and is never preempted.
// - Find and strip preamble, extract addresses and length, pass data on.
// - Check CRC over each frame against its FCS; mismatch is an error.
// - Jabber timer catches frames that reach the maximum length or run longer.
// - Write data into the FIFO and record errors in a flag byte.
// - Device may pull the duplex line low; PHY then runs half duplex.
// - Duplex pin is sensed and can be actively pulled down.
// - All logic runs from the single system clock.
// - Reset is active low and synchronous; host holds it for 25 ms.
// - Full duplex ignores carrier sense and disables collision detection.
// - Frames under 64 bytes are discarded before leaving the FIFO path.
`timescale 1ns/100ps
`include "rmacd_defs.svh"
module rmacd_top #(
  parameter int STAGE      = `RMACD_STAGE_DEPTH,
  parameter int FIFO_DEPTH = `RMACD_FIFO_DEPTH,
  parameter int MIN_BYTES  = `RMACD_MIN_BYTES,
  parameter int MAX_BYTES  = `RMACD_MAX_BYTES
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             link_rx_clk,
  input  wire logic             link_rx_dv,
  input  wire logic [3:0]       link_rxd,
  input  wire logic             link_crs,
  input  wire logic             link_col,
  input  wire logic             port_duplex_line_in,
  output logic                  port_duplex_line_out,
  output logic                  port_duplex_line_oe,
  input  wire logic             force_half_duplex,
  input  wire logic             receive_priority_enable,
  input  wire logic             tx_pending,
  input  wire logic             tx_active,
  output logic                  rx_grant,
  output logic                  tx_grant,
  output logic                  full_duplex,
  output logic                  carrier_sense,
  output logic                  collision,
  output rmacd_pkg::rmacd_hdr_t frame_header,
  output logic                  header_valid,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output rmacd_pkg::rmacd_word_t out_word
);
  localparam int CW  = $clog2(MAX_BYTES + 1);
  localparam int SAW = $clog2(STAGE);
  localparam int STW = SAW + 1;
  localparam int WW  = $bits(rmacd_pkg::rmacd_word_t);

  // ----------------------------------------------------------------
  // Link sampling
  // ----------------------------------------------------------------
  rmacd_pkg::rmacd_pins_t pin_raw;
  rmacd_pkg::rmacd_pins_t pin_meta;
  rmacd_pkg::rmacd_pins_t pin_sync;
  logic                   clk_prev;
  wire                    rx_tick;

  assign pin_raw = {link_rx_clk, link_rx_dv, link_rxd, link_crs, link_col,
                    port_duplex_line_in};
  // Data is sampled on the rising edge seen here; it is stable for half a link period
  assign rx_tick = pin_sync.rx_clk && !clk_prev;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      pin_meta <= '0;
      pin_sync <= '0;
      clk_prev <= 1'b0;
    end else begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
      clk_prev <= pin_sync.rx_clk;
    end
  end

  // ----------------------------------------------------------------
  // Duplex line and carrier masking
  // ----------------------------------------------------------------
  wire next_fdx = !force_half_duplex && pin_sync.duplex;
  wire col_eff  = pin_sync.col && !next_fdx;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      port_duplex_line_out <= 1'b0;
      port_duplex_line_oe <= 1'b0;
      full_duplex         <= 1'b0;
      carrier_sense       <= 1'b0;
      collision           <= 1'b0;
    end else begin
      // Open-drain: only ever pulls low, never drives high
      port_duplex_line_out <= 1'b0;
      port_duplex_line_oe <= force_half_duplex;
      full_duplex         <= next_fdx;
      carrier_sense       <= pin_sync.crs && !next_fdx;
      collision           <= col_eff;
    end
  end

  // ----------------------------------------------------------------
  // Receive frame control
  // ----------------------------------------------------------------
  rmacd_pkg::rmacd_rx_state_t rx_state;
  rmacd_pkg::rmacd_rx_state_t next_state;
  logic                       half;
  logic [3:0]                 lo_nib;
  logic [CW-1:0]              byte_cnt;
  logic                       committed;
  logic                       err_ovf;
  logic                       err_col;
  logic                       crc_ok;
  logic [7:0]                 flag_byte;

  wire in_data   = rx_state == rmacd_pkg::RMACD_DATA;
  wire sfd_seen  = rx_tick && rx_state == rmacd_pkg::RMACD_PRE && pin_sync.rx_dv &&
                   pin_sync.rxd == `RMACD_NIB_SFD;
  wire nib_in    = rx_tick && in_data && pin_sync.rx_dv;
  wire byte_done = nib_in && half;
  wire frame_end = rx_tick && in_data && !pin_sync.rx_dv;
  wire jabber    = byte_cnt >= CW'(MAX_BYTES);

  always_comb begin
    next_state = rx_state;
    case (rx_state)
      rmacd_pkg::RMACD_IDLE: begin
        if (rx_tick && pin_sync.rx_dv) begin
          next_state = (pin_sync.rxd == `RMACD_NIB_PRE) ? rmacd_pkg::RMACD_PRE
                                                        : rmacd_pkg::RMACD_SKIP;
        end
      end
      rmacd_pkg::RMACD_PRE: begin
        if (rx_tick && !pin_sync.rx_dv) begin
          next_state = rmacd_pkg::RMACD_IDLE;
        end else if (sfd_seen) begin
          next_state = rmacd_pkg::RMACD_DATA;
        end else if (rx_tick && pin_sync.rxd != `RMACD_NIB_PRE) begin
          next_state = rmacd_pkg::RMACD_SKIP;
        end
      end
      rmacd_pkg::RMACD_DATA: begin
        if (frame_end) begin
          next_state = rmacd_pkg::RMACD_IDLE;
        end
      end
      rmacd_pkg::RMACD_SKIP: begin
        if (rx_tick && !pin_sync.rx_dv) begin
          next_state = rmacd_pkg::RMACD_IDLE;
        end
      end
      default: next_state = rmacd_pkg::RMACD_IDLE;
    endcase
  end

  always_comb begin
    flag_byte                 = 8'h00;
    flag_byte[`RMACD_FLG_CRC] = !crc_ok;
    flag_byte[`RMACD_FLG_JAB] = jabber;
    flag_byte[`RMACD_FLG_OVF] = err_ovf;
    flag_byte[`RMACD_FLG_ALN] = half;
    flag_byte[`RMACD_FLG_COL] = err_col;
  end

  rmacd_crc32 u_crc (
    .clk    (clk),
    .rst_n  (rst_n),
    .clear  (sfd_seen),
    .en     (nib_in),
    .nib    (pin_sync.rxd),
    .crc_ok (crc_ok)
  );

  // ----------------------------------------------------------------
  // Staging buffer: holds a frame until it proves long enough
  // ----------------------------------------------------------------
  rmacd_pkg::rmacd_word_t st_mem [STAGE];
  rmacd_pkg::rmacd_word_t st_wdata;
  logic [STW-1:0]         st_wr;
  logic [STW-1:0]         st_rd;
  logic [STW-1:0]         st_rel;
  logic [STW-1:0]         st_start;
  logic                   f_in_ready;

  // One slot always kept free so the flag byte can never be lost
  wire st_room   = STW'(st_wr - st_rd) < STW'(STAGE - 1);
  wire push_byte = byte_done && !jabber && st_room;
  wire push_flag = frame_end && committed;
  wire st_push   = push_byte || push_flag;
  wire st_pop    = (st_rd != st_rel) && f_in_ready;
  wire rx_busy   = in_data || rx_state == rmacd_pkg::RMACD_PRE || st_rd != st_rel;

  assign st_wdata = push_flag ? {1'b1, flag_byte} : {1'b0, pin_sync.rxd, lo_nib};

  always_ff @(posedge clk) begin
    if (st_push) begin
      st_mem[st_wr[SAW-1:0]] <= st_wdata;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_state  <= rmacd_pkg::RMACD_IDLE;
      half      <= 1'b0;
      lo_nib    <= 4'h0;
      byte_cnt  <= '0;
      committed <= 1'b0;
      err_ovf   <= 1'b0;
      err_col   <= 1'b0;
    end else begin
      rx_state <= next_state;
      if (sfd_seen) begin
        half      <= 1'b0;
        byte_cnt  <= '0;
        committed <= 1'b0;
        err_ovf   <= 1'b0;
        err_col   <= 1'b0;
      end else begin
        if (nib_in) begin
          half   <= !half;
          lo_nib <= pin_sync.rxd;
        end
        if (byte_done && !jabber) begin
          byte_cnt <= byte_cnt + 1'b1;
        end
        if (byte_done && byte_cnt == CW'(MIN_BYTES - 1)) begin
          committed <= 1'b1;
        end
        err_ovf <= err_ovf || (byte_done && !jabber && !st_room);
        err_col <= err_col || (in_data && col_eff);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_wr    <= '0;
      st_rd    <= '0;
      st_rel   <= '0;
      st_start <= '0;
    end else begin
      if (frame_end && !committed) begin
        st_wr <= st_start;
      end else if (st_push) begin
        st_wr <= st_wr + 1'b1;
      end
      st_start <= sfd_seen ? st_wr : st_start;
      st_rel   <= committed ? st_wr : st_rel;
      st_rd    <= st_pop ? st_rd + 1'b1 : st_rd;
    end
  end

  // ----------------------------------------------------------------
  // Header extraction
  // ----------------------------------------------------------------
  wire [7:0] rx_byte = {pin_sync.rxd, lo_nib};

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      frame_header <= '0;
      header_valid <= 1'b0;
    end else begin
      header_valid <= byte_done && byte_cnt == CW'(`RMACD_LEN_END - 1);
      if (byte_done && byte_cnt < CW'(`RMACD_DA_END)) begin
        frame_header.dest <= {frame_header.dest[39:0], rx_byte};
      end else if (byte_done && byte_cnt < CW'(`RMACD_SA_END)) begin
        frame_header.src <= {frame_header.src[39:0], rx_byte};
      end else if (byte_done && byte_cnt < CW'(`RMACD_LEN_END)) begin
        frame_header.len <= {frame_header.len[7:0], rx_byte};
      end
    end
  end

  // ----------------------------------------------------------------
  // Receive FIFO and registered output stage
  // ----------------------------------------------------------------
  logic          f_valid;
  logic [WW-1:0] f_data;
  wire           f_take = f_valid && (!out_valid || out_ready);

  rmacd_fifo #(
    .W     (WW),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .rst_n     (rst_n),
    .in_valid  (st_rd != st_rel),
    .in_ready  (f_in_ready),
    .in_data   (st_mem[st_rd[SAW-1:0]]),
    .out_valid (f_valid),
    .out_ready (!out_valid || out_ready),
    .out_data  (f_data)
  );

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      out_valid <= 1'b0;
      out_word  <= '0;
    end else begin
      out_valid <= f_take || (out_valid && !out_ready);
      out_word  <= f_take ? f_data : out_word;
    end
  end

  // ----------------------------------------------------------------
  // Receive versus transmit arbitration
  // ----------------------------------------------------------------
  // Without receive priority the arbiter falls back to transmit first
  wire rx_first = receive_priority_enable || !tx_pending;
  wire next_tx  = tx_active || (tx_pending && !(rx_busy && rx_first));
  wire next_rx  = !tx_active && rx_busy && rx_first;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      rx_grant <= 1'b0;
      tx_grant <= 1'b0;
    end else begin
      rx_grant <= next_rx;
      tx_grant <= next_tx;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  arb_tx_hold_a: assert property (tx_active |=> tx_grant && !rx_grant)
    else $error("active transmit lost its grant");
  arb_rx_first_a: assert property (
    !tx_active && tx_pending && rx_busy && receive_priority_enable |=> rx_grant && !tx_grant)
    else $error("pending transmit beat receive");
  duplex_force_a: assert property (
    force_half_duplex |=> port_duplex_line_oe && !port_duplex_line_out && !full_duplex)
    else $error("force half did not pull the line low");
  duplex_sense_a: assert property (
    !force_half_duplex && pin_sync.duplex |=> full_duplex)
    else $error("line high not seen as full duplex");
  fdx_mask_a: assert property (full_duplex |-> !carrier_sense && !collision)
    else $error("carrier or collision seen in full duplex");
  sfd_strip_a: assert property (sfd_seen |=> in_data && byte_cnt == '0 && !half)
    else $error("start delimiter did not open a frame");
  short_drop_a: assert property (frame_end && !committed |=> st_wr == st_start)
    else $error("short frame not discarded");
  crc_flag_a: assert property (push_flag && !crc_ok |=>
    st_mem[SAW'(st_wr - 1'b1)].is_flag &&
    st_mem[SAW'(st_wr - 1'b1)].byte_val[`RMACD_FLG_CRC])
    else $error("bad CRC not flagged");
  jab_stop_a: assert property (byte_done && jabber |=> st_wr == $past(st_wr))
    else $error("byte stored past maximum length");
  // Own disable: the default one would mute this check during reset itself
  reset_idle_a: assert property (@(posedge clk) disable iff (1'b0) !rst_n |=>
    rx_state == rmacd_pkg::RMACD_IDLE && !out_valid && !rx_grant && !tx_grant)
    else $error("reset did not clear state");
endmodule

//--- rmacd_defs.svh
// Constants for the receive MAC and duplex control block
`ifndef RMACD_DEFS_SVH
`define RMACD_DEFS_SVH
`define RMACD_CLK_HZ      20_000_000
`define RMACD_RST_HOLD_MS 25
`define RMACD_NIB_PRE     4'h5
`define RMACD_NIB_SFD     4'hD
`define RMACD_MIN_BYTES   64
`define RMACD_MAX_BYTES   1518
`define RMACD_STAGE_DEPTH 128
`define RMACD_FIFO_DEPTH  8
`define RMACD_CRC_INIT    32'hFFFFFFFF
`define RMACD_CRC_POLY    32'hEDB88320
`define RMACD_CRC_GOOD    32'hDEBB20E3
`define RMACD_FLG_CRC     0
`define RMACD_FLG_JAB     1
`define RMACD_FLG_OVF     2
`define RMACD_FLG_ALN     3
`define RMACD_FLG_COL     4
`define RMACD_DA_END      6
`define RMACD_SA_END      12
`define RMACD_LEN_END     14
`endif

//--- rmacd_pkg.sv
// Types shared by the receive MAC and duplex control block
package rmacd_pkg;
  typedef struct packed {
    logic       is_flag;
    logic [7:0] byte_val;
  } rmacd_word_t;

  typedef struct packed {
    logic [47:0] dest;
    logic [47:0] src;
    logic [15:0] len;
  } rmacd_hdr_t;

  typedef struct packed {
    logic       rx_clk;
    logic       rx_dv;
    logic [3:0] rxd;
    logic       crs;
    logic       col;
    logic       duplex;
  } rmacd_pins_t;

  typedef enum logic [1:0] {
    RMACD_IDLE,
    RMACD_PRE,
    RMACD_DATA,
    RMACD_SKIP
  } rmacd_rx_state_t;
endpackage

//--- rmacd_fifo.sv
// Receive FIFO with valid and ready on both sides
`timescale 1ns/100ps
module rmacd_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic [W-1:0]      out_data
);
  localparam int AW = $clog2(DEPTH);

  logic [W-1:0]  mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0]   count;
  wire           push = in_valid && in_ready;
  wire           pop  = out_valid && out_ready;

  assign in_ready  = count != (AW+1)'(DEPTH);
  assign out_valid = count != '0;
  assign out_data  = mem[rd_ptr];

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr] <= in_data;
    end
  end

  // Pointer wrap relies on DEPTH being a power of two
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count  <= '0;
    end else begin
      wr_ptr <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count  <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (count == (AW+1)'(DEPTH)) && !pop |=> count == (AW+1)'(DEPTH) && !in_ready)
    else $error("fifo accepted a word while full");
endmodule

//--- rmacd_crc32.sv
// Nibble-wide CRC-32 over a received frame, low bit first
`timescale 1ns/100ps
`include "rmacd_defs.svh"
module rmacd_crc32 (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       en,
  input  wire logic [3:0] nib,
  output logic            crc_ok
);
  logic [31:0] crc;
  logic [31:0] step [0:4];

  assign step[0] = crc;
  for (genvar i = 0; i < 4; i++) begin : g_bit
    assign step[i+1] = (step[i] >> 1) ^
                       ((step[i][0] ^ nib[i]) ? `RMACD_CRC_POLY : 32'h00000000);
  end

  // FCS folded in leaves the fixed residue when the frame is intact
  assign crc_ok = crc == `RMACD_CRC_GOOD;

  always_ff @(posedge clk) begin
    if (!rst_n || clear) begin
      crc <= `RMACD_CRC_INIT;
    end else if (en) begin
      crc <= step[4];
    end
  end
endmodule

//--- rmacd_phy_model.sv
// Behavioural PHY: nibble receive link and the duplex line
`timescale 1ns/100ps
`include "rmacd_defs.svh"
module rmacd_phy_model (
  output logic       rx_clk,
  output logic       rx_dv,
  output logic [3:0] rxd,
  output logic       crs,
  output logic       col,
  output logic       duplex_drive,
  input  wire logic  duplex_line,
  output logic       half_mode
);
  logic [7:0] sent[$];

  initial begin
    rx_clk = 1'b0;
    rx_dv = 1'b0;
    rxd = 4'hA;
    crs = 1'b0;
    col = 1'b0;
  end

  // Weak high only; the pull-up holds the line high while released
  assign duplex_drive = 1'b1;
  // Half duplex as soon as the device pulls the line low
  assign half_mode = !duplex_line;

  // Receive clock runs only inside frames
  task automatic nib(input logic [3:0] v);
    rxd = v;
    #200 rx_clk = 1'b1;
    #200 rx_clk = 1'b0;
  endtask

  // n body bytes, then FCS low byte first; options corrupt, add a nibble, collide
  task automatic send(input int n, input bit bad, input bit odd, input bit c);
    logic [31:0] r;
    r = `RMACD_CRC_INIT;
    sent.delete();
    for (int i = 0; i < n; i++) begin
      sent.push_back(8'(i * 7 + 17));
      for (int k = 0; k < 8; k++) r = (r[0] ^ sent[i][k]) ? (r >> 1) ^ `RMACD_CRC_POLY : r >> 1;
    end
    r = ~r;
    for (int i = 0; i < 4; i++) sent.push_back(r[8*i +: 8] ^ {7'h00, bad && i == 0});
    rx_dv = 1'b1;
    crs = 1'b1;
    col = c;
    for (int i = 0; i < 15; i++) nib(4'h5);
    nib(4'hD);
    foreach (sent[i]) begin
      nib(sent[i][3:0]);
      nib(sent[i][7:4]);
    end
    if (odd) nib(4'h6);
    rx_dv = 1'b0;
    crs = 1'b0;
    col = 1'b0;
    // One more edge so the end of frame is sampled; data line then shows no stale value
    nib(~rxd);
  endtask
endmodule

//--- tb_top.sv
// Self-checking bench for the receive MAC and duplex control block
`timescale 1ns/100ps
module tb_top;
  localparam int MAXB = 80;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic force_half_duplex = 1'b0;
  logic receive_priority_enable = 1'b1;
  logic tx_pending = 1'b0;
  logic tx_active = 1'b0;
  logic out_ready = 1'b1;
  logic rx_clk, rx_dv, crs, col, dup_drv, half_mode, line_out, line_oe, line;
  logic [3:0] rxd;
  logic rx_grant, tx_grant, full_duplex, carrier_sense, collision;
  logic header_valid, out_valid;
  rmacd_pkg::rmacd_hdr_t  frame_header, hdr_seen;
  rmacd_pkg::rmacd_word_t out_word;
  rmacd_pkg::rmacd_word_t got[$];
  int fail_count = 0;
  int n_tests = 0;
  int hv_count = 0;

  always #25 clk = ~clk;

  // Device pull-down wins over the PHY's weak high
  assign line = line_oe ? line_out : dup_drv;

  rmacd_phy_model i_rmacd_phy_model (
    .rx_clk(rx_clk), .rx_dv(rx_dv), .rxd(rxd), .crs(crs), .col(col),
    .duplex_drive(dup_drv), .duplex_line(line), .half_mode(half_mode)
  );

  rmacd_top #(.MAX_BYTES(MAXB)) i_rmacd_top (
    .clk(clk), .rst_n(rst_n), .link_rx_clk(rx_clk), .link_rx_dv(rx_dv),
    .link_rxd(rxd), .link_crs(crs), .link_col(col), .port_duplex_line_in(line),
    .port_duplex_line_out(line_out), .port_duplex_line_oe(line_oe),
    .force_half_duplex(force_half_duplex), .receive_priority_enable(receive_priority_enable),
    .tx_pending(tx_pending), .tx_active(tx_active), .rx_grant(rx_grant),
    .tx_grant(tx_grant), .full_duplex(full_duplex), .carrier_sense(carrier_sense),
    .collision(collision), .frame_header(frame_header), .header_valid(header_valid),
    .out_valid(out_valid), .out_ready(out_ready), .out_word(out_word)
  );

  always @(posedge clk) begin
    if (rst_n && out_valid && out_ready) got.push_back(out_word);
    if (rst_n && header_valid) begin
      hv_count++;
      hdr_seen = frame_header;
    end
  end

  // ----------------------------------------
  // Shared helpers
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] seen, input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic summarize;
    if (fail_count == 0 && n_tests > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic ticks(input int n);
    repeat (n) @(negedge clk);
  endtask

  task automatic send(input int n, input bit bad, input bit odd, input bit c);
    got.delete();
    hv_count = 0;
    i_rmacd_phy_model.send(n, bad, odd, c);
  endtask

  // Bounded wait for the flag word that closes a frame
  task automatic wait_flag;
    for (int t = 0; t < 3000; t++) begin
      if (got.size() > 0 && got[$].is_flag) break;
      @(negedge clk);
    end
  endtask

  task automatic check_frame(input int nexp, input logic [7:0] mask, input logic [7:0] fexp);
    check("count", got.size(), nexp + 1);
    for (int i = 0; i < nexp && i < got.size() - 1; i++)
      check("byte", {55'h0, got[i]}, {56'h0, i_rmacd_phy_model.sent[i]});
    if (got.size() > 0) check("flag", {55'h0, got[$] & {1'b1, mask}}, {56'h1, fexp});
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_duplex;
    force_half_duplex = 1'b1;
    ticks(5);
    check("oe", line_oe, 1);
    check("pull_value", line_out, 0);
    check("phy_half", half_mode, 1);
    check("full_forced", full_duplex, 0);
    force_half_duplex = 1'b0;
    ticks(5);
    check("oe_off", line_oe, 0);
    check("full_line", full_duplex, 1);
  endtask

  task automatic t_arb;
    tx_pending = 1'b1;
    ticks(3);
    check("grant_idle", {rx_grant, tx_grant}, 2'b01);
    fork
      send(60, 0, 0, 0);
      begin
        ticks(300);
        check("grant_rx", {rx_grant, tx_grant}, 2'b10);
        // Without receive priority a pending transmit goes first
        receive_priority_enable = 1'b0;
        ticks(2);
        check("grant_nopri", {rx_grant, tx_grant}, 2'b01);
        receive_priority_enable = 1'b1;
        tx_active = 1'b1;
        ticks(2);
        check("grant_tx", {rx_grant, tx_grant}, 2'b01);
        tx_active = 1'b0;
        tx_pending = 1'b0;
      end
    join
    wait_flag();
  endtask

  // Output held back until the FIFO fills and the rest of the frame waits in staging, then drained
  task automatic t_good;
    logic [111:0] exp;
    out_ready = 1'b0;
    send(60, 0, 0, 0);
    ticks(40);
    check("stall_valid", out_valid, 1);
    check("stall_none", got.size(), 0);
    out_ready = 1'b1;
    wait_flag();
    check_frame(64, 8'hFF, 8'h00);
    check("hdr_pulses", hv_count, 1);
    for (int i = 0; i < 14; i++) exp = {exp[103:0], i_rmacd_phy_model.sent[i]};
    check("dest", hdr_seen.dest, exp[111:64]);
    check("src", hdr_seen.src, exp[63:16]);
    check("len", hdr_seen.len, exp[15:0]);
    ticks(5);
    check("drained", out_valid, 0);
  endtask

  task automatic t_crc;
    send(60, 1, 0, 0);
    wait_flag();
    check_frame(64, 8'h01, 8'h01);
  endtask

  task automatic t_short;
    send(59, 0, 0, 0);
    ticks(400);
    check("short_none", got.size(), 0);
  endtask

  task automatic t_jabber;
    send(86, 0, 0, 0);
    wait_flag();
    check_frame(MAXB, 8'h02, 8'h02);
  endtask

  task automatic t_align;
    send(60, 0, 1, 0);
    wait_flag();
    check_frame(64, 8'h08, 8'h08);
  endtask

  // Carrier and collision only count in half duplex
  task automatic t_col(input bit half);
    force_half_duplex = half;
    ticks(5);
    fork
      send(60, 0, 0, 1);
      begin
        ticks(300);
        check("carrier", carrier_sense, half);
        check("collision", collision, half);
      end
    join
    wait_flag();
    check_frame(64, 8'h10, {3'h0, half, 4'h0});
    force_half_duplex = 1'b0;
    ticks(5);
  endtask

  initial begin
    ticks(2);
    check("rst_oe", line_oe, 0);
    check("rst_grant", {rx_grant, tx_grant}, 2'b00);
    check("rst_valid", {out_valid, header_valid}, 2'b00);
    rst_n = 1'b1;
    ticks(2);
    t_duplex();
    t_arb();
    t_good();
    t_crc();
    t_short();
    t_jabber();
    t_align();
    t_col(1'b0);
    t_col(1'b1);
    summarize();
  end

  // Eight frames of under 80 us each fit well inside this span
  initial begin
    #3_000_000;
    fail_count++;
    summarize();
  end
endmodule
